// *** rtl/sdrpd_pkg.sv ***
package sdrpd_pkg;

  localparam int CLK_MHZ = 125;

  // Times in ns, or in clock periods where marked _CK
  localparam int T_RFC_NS    = 160;
  localparam int T_REFI_NS   = 7800;
  localparam int T_RP_NS     = 14;
  localparam int T_XS_NS     = 170;
  localparam int T_XSDLL_CK  = 512;
  localparam int T_CKE_NS    = 8;
  localparam int T_CKESR_NS  = 16;
  localparam int T_CKSRE_NS  = 10;
  localparam int T_CKSRX_NS  = 10;
  localparam int T_CPDED_NS  = 8;
  localparam int T_XP_NS     = 8;
  localparam int T_XPDLL_NS  = 24;
  localparam int T_ODTL_CK   = 6;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  localparam int C_RFC   = cyc_min(T_RFC_NS);
  localparam int C_REFI  = (T_REFI_NS * CLK_MHZ) / 1000;
  localparam int C_RP    = cyc_min(T_RP_NS);
  localparam int C_XS    = cyc_min(T_XS_NS);
  localparam int C_XSDLL = imax(T_XSDLL_CK, C_XS + 1);
  localparam int C_CKESR = imax(cyc_min(T_CKESR_NS), cyc_min(T_CKSRE_NS) + 1);
  localparam int C_CKSRE = cyc_min(T_CKSRE_NS);
  localparam int C_CKSRX = cyc_min(T_CKSRX_NS);
  localparam int C_PDMIN = imax(cyc_min(T_CKE_NS), cyc_min(T_CPDED_NS));
  localparam int C_XP    = imax(cyc_min(T_XP_NS), cyc_min(T_CKE_NS));
  localparam int C_XPDLL = imax(cyc_min(T_XPDLL_NS), C_XP);
  localparam int C_ODTOFF = T_ODTL_CK + 1;

  localparam int TMR_W  = 16;
  localparam int REFI_W = 10;
  localparam int ROW_W  = 15;

  localparam logic signed [4:0] DEBT_MAX = 5'sh08;
  localparam logic signed [4:0] DEBT_MIN = -5'sh08;

  typedef enum logic [2:0] {
    SDRPD_DES, SDRPD_NOP, SDRPD_REF, SDRPD_ACT, SDRPD_PRE, SDRPD_OTH
  } sdrpd_cmd_t;

  typedef enum logic [2:0] {
    SDRPD_M_IDLE, SDRPD_M_ACTIVE, SDRPD_M_REF, SDRPD_M_SREF, SDRPD_M_PD
  } sdrpd_mode_t;

  function automatic sdrpd_cmd_t cmd_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    sdrpd_cmd_t c;
    c = SDRPD_OTH;
    if (cs_n)
      c = SDRPD_DES;
    else
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h7:    c = SDRPD_NOP;
        3'h1:    c = SDRPD_REF;
        3'h3:    c = SDRPD_ACT;
        3'h2:    c = SDRPD_PRE;
        default: c = SDRPD_OTH;
      endcase
    end
    return c;
  endfunction : cmd_decode

endpackage : sdrpd_pkg

// *** rtl/sdrpd_if.sv ***
`timescale 1ns/1ps
interface sdrpd_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic reset_n;
  logic clk_run;

  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, clk_run);
  modport mem (input  cke, cs_n, ras_n, cas_n, we_n, odt, reset_n, clk_run);
endinterface : sdrpd_if

// *** rtl/sdrpd_mem_end.sv ***
`timescale 1ns/1ps
module sdrpd_mem_end (
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  sdrpd_if.mem                         bus,
  input  wire logic                    mr1_dll_dis,
  input  wire logic                    mr0_pd_fast,
  output sdrpd_pkg::sdrpd_mode_t       mode,
  output logic [sdrpd_pkg::ROW_W-1:0]  ref_row,
  output logic                         ref_pulse,
  output logic                         dll_on,
  output logic                         dll_rst,
  output logic                         pd_slow,
  output logic                         bank_open,
  output logic                         rtt_on
);

  typedef struct packed {
    sdrpd_pkg::sdrpd_mode_t     mode;
    logic                       bank_open;
    logic                       cke_q;
    logic [sdrpd_pkg::ROW_W-1:0] row;
    logic [sdrpd_pkg::TMR_W-1:0] tmr;
    logic                       dll_on;
    logic                       dll_rst;
    logic                       pd_slow;
    logic                       ref_pulse;
    logic                       rtt;
  } sdrpd_mst_t;

  sdrpd_mst_t         s_r;
  sdrpd_mst_t         s_nxt;
  sdrpd_pkg::sdrpd_cmd_t cmd;

  assign cmd = sdrpd_pkg::cmd_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cke_q = bus.cke;
    s_nxt.ref_pulse = 1'b0;
    s_nxt.dll_rst = 1'b0;
    unique case (s_r.mode)
      sdrpd_pkg::SDRPD_M_IDLE, sdrpd_pkg::SDRPD_M_ACTIVE:
      begin
        if (s_r.cke_q && cmd == sdrpd_pkg::SDRPD_REF && bus.cke)
        begin
          s_nxt.mode = sdrpd_pkg::SDRPD_M_REF;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_RFC - 1);
          s_nxt.row = s_r.row + 1'b1;
          s_nxt.ref_pulse = 1'b1;
        end
        else if (s_r.cke_q && cmd == sdrpd_pkg::SDRPD_REF && !bus.cke)
        begin
          s_nxt.mode = sdrpd_pkg::SDRPD_M_SREF;
          s_nxt.dll_on = mr1_dll_dis ? s_r.dll_on : 1'b0;
          s_nxt.row = s_r.row + 1'b1;
          s_nxt.ref_pulse = 1'b1;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_REFI - 1);
        end
        else if (s_r.cke_q && !bus.cke &&
                 (cmd == sdrpd_pkg::SDRPD_NOP || cmd == sdrpd_pkg::SDRPD_DES))
        begin
          s_nxt.mode = sdrpd_pkg::SDRPD_M_PD;
          s_nxt.pd_slow = !s_r.bank_open && !mr0_pd_fast;
          if (!s_r.bank_open && !mr0_pd_fast)
            s_nxt.dll_on = 1'b0;
        end
        else
        begin
          if (cmd == sdrpd_pkg::SDRPD_ACT)
            s_nxt.bank_open = 1'b1;
          else if (cmd == sdrpd_pkg::SDRPD_PRE)
            s_nxt.bank_open = 1'b0;
          s_nxt.mode = s_nxt.bank_open ? sdrpd_pkg::SDRPD_M_ACTIVE : sdrpd_pkg::SDRPD_M_IDLE;
        end
      end
      sdrpd_pkg::SDRPD_M_REF:
      begin
        if (s_r.tmr == '0)
        begin
          s_nxt.mode = sdrpd_pkg::SDRPD_M_IDLE;
          s_nxt.bank_open = 1'b0;
        end
        else
          s_nxt.tmr = s_r.tmr - 1'b1;
      end
      sdrpd_pkg::SDRPD_M_SREF:
      begin
        // Own timer keeps refreshing; only CKE and RESET are watched
        if (s_r.tmr == '0)
        begin
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_REFI - 1);
          s_nxt.row = s_r.row + 1'b1;
          s_nxt.ref_pulse = 1'b1;
        end
        else
          s_nxt.tmr = s_r.tmr - 1'b1;
        if (bus.cke)
        begin
          s_nxt.mode = sdrpd_pkg::SDRPD_M_IDLE;
          if (!mr1_dll_dis)
          begin
            s_nxt.dll_on = 1'b1;
            s_nxt.dll_rst = 1'b1;
          end
        end
      end
      sdrpd_pkg::SDRPD_M_PD:
      begin
        if (bus.cke)
        begin
          s_nxt.mode = s_r.bank_open ? sdrpd_pkg::SDRPD_M_ACTIVE : sdrpd_pkg::SDRPD_M_IDLE;
          if (s_r.pd_slow)
            s_nxt.dll_on = !mr1_dll_dis;
          s_nxt.pd_slow = 1'b0;
        end
      end
      default: s_nxt.mode = sdrpd_pkg::SDRPD_M_IDLE;
    endcase
    s_nxt.rtt = bus.odt && s_nxt.mode != sdrpd_pkg::SDRPD_M_SREF;
    if (!bus.reset_n)
    begin
      s_nxt.mode = sdrpd_pkg::SDRPD_M_IDLE;
      s_nxt.bank_open = 1'b0;
      s_nxt.pd_slow = 1'b0;
      s_nxt.rtt = 1'b0;
      s_nxt.dll_on = !mr1_dll_dis;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{mode: sdrpd_pkg::SDRPD_M_IDLE, dll_on: 1'b1, default: '0};
    end
    else
      s_r <= s_nxt;
  end

  assign mode      = s_r.mode;
  assign ref_row   = s_r.row;
  assign ref_pulse = s_r.ref_pulse;
  assign dll_on    = s_r.dll_on;
  assign dll_rst   = s_r.dll_rst;
  assign pd_slow   = s_r.pd_slow;
  assign bank_open = s_r.bank_open;
  assign rtt_on    = s_r.rtt;

endmodule : sdrpd_mem_end

// *** rtl/sdrpd_ctl_end.sv ***
// Behaviour
// - REF pattern issued once per wanted refresh
// - All banks idle for tRP before REF
// - Device counts rows, ends all banks precharged
// - Only NOP/deselect until tRFC elapses
// - At most eight refreshes postponed
// - At most eight pulled in, no more credit
// - No more than sixteen REF per two tREFI; not counted here, only the debt limits apply
// - Debt frozen in self-refresh, total eight
// - Self-refresh entry is REF with CKE low
// - Banks idle and ODT low before entry
// - CKE held low at least tCKESR
// - Device DLL off in, on with reset out
// - Device ignores inputs but CKE, RESET in self-refresh
// - Device refreshes once within tCKE after entry
// - Clock may stop after tCKSRE, stable tCKSRX
// - Exit: CKE high with NOP, wait tXS/tXSDLL
// - NOP through tXS, CKE high, ODT off tXSDLL
// - Extra refresh after exit before re-entry
// - Power-down is CKE low with NOP
// - Device picks active or precharge power-down mode
// - Exit after tXP, slow exit tXPDLL
// - NOP for tCPDED, hold tCKE, stay limited
`timescale 1ns/1ps
module sdrpd_ctl_end (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  sdrpd_if.ctl              bus,
  input  wire logic         banks_idle,
  input  wire logic         defer_ref,
  input  wire logic         pull_ref,
  input  wire logic         sref_req,
  input  wire logic         pd_req,
  input  wire logic         pd_fast,
  input  wire logic         odt_req,
  output logic              busy,
  output logic              in_sref,
  output logic              in_pd,
  output logic              ref_sent,
  output logic signed [4:0] debt
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RFC, ST_SRE_ODT, ST_SREF, ST_SRX_CLK, ST_SRX_XS, ST_SRX_DLL, ST_PD, ST_PDX
  } sdrpd_cst_t;

  typedef struct packed {
    sdrpd_cst_t                   st;
    logic signed [4:0]            debt;
    logic [sdrpd_pkg::REFI_W-1:0] refi;
    logic [sdrpd_pkg::TMR_W-1:0]  tmr;
    logic [sdrpd_pkg::TMR_W-1:0]  rp;
    logic                         need_ref;
    logic                         cke;
    logic                         cs_n;
    logic                         ras_n;
    logic                         cas_n;
    logic                         we_n;
    logic                         odt;
    logic                         clk_run;
    logic                         ref_sent;
  } sdrpd_cst_reg_t;

  sdrpd_cst_reg_t s_r;
  sdrpd_cst_reg_t s_nxt;

  logic tick;
  logic frozen;
  logic rp_ok;
  logic dec;

  assign tick   = s_r.refi == sdrpd_pkg::REFI_W'(sdrpd_pkg::C_REFI - 1);
  assign frozen = s_r.st inside {ST_SRE_ODT, ST_SREF, ST_SRX_CLK};
  assign rp_ok  = banks_idle && s_r.rp == sdrpd_pkg::TMR_W'(sdrpd_pkg::C_RP);

  always_comb
  begin
    s_nxt = s_r;
    dec = 1'b0;
    s_nxt.ref_sent = 1'b0;
    s_nxt.cs_n = 1'b0;
    s_nxt.ras_n = 1'b1;
    s_nxt.cas_n = 1'b1;
    s_nxt.we_n = 1'b1;
    if (!frozen)
      s_nxt.refi = tick ? '0 : s_r.refi + 1'b1;
    if (!banks_idle)
      s_nxt.rp = '0;
    else if (!rp_ok)
      s_nxt.rp = s_r.rp + 1'b1;
    if (s_r.tmr != '0)
      s_nxt.tmr = s_r.tmr - 1'b1;
    unique case (s_r.st)
      ST_IDLE:
      begin
        s_nxt.cke = 1'b1;
        if (rp_ok && (s_r.debt == sdrpd_pkg::DEBT_MAX ||
            (s_r.debt > 5'sh00 && !defer_ref) || s_r.need_ref ||
            (pull_ref && s_r.debt != sdrpd_pkg::DEBT_MIN)))
        begin
          s_nxt.ras_n = 1'b0;
          s_nxt.cas_n = 1'b0;
          s_nxt.st = ST_RFC;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_RFC - 1);
          s_nxt.need_ref = 1'b0;
          s_nxt.ref_sent = 1'b1;
          dec = 1'b1;
        end
        else if (sref_req && rp_ok && s_r.debt != sdrpd_pkg::DEBT_MAX)
        begin
          s_nxt.st = ST_SRE_ODT;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_ODTOFF);
        end
        else if (pd_req && s_r.debt != sdrpd_pkg::DEBT_MAX)
        begin
          s_nxt.cke = 1'b0;
          s_nxt.st = ST_PD;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_PDMIN);
        end
      end
      ST_RFC:
      begin
        if (s_r.tmr == '0)
          s_nxt.st = ST_IDLE;
      end
      ST_SRE_ODT:
      begin
        if (s_r.tmr == '0 && rp_ok)
        begin
          s_nxt.ras_n = 1'b0;
          s_nxt.cas_n = 1'b0;
          s_nxt.cke = 1'b0;
          s_nxt.st = ST_SREF;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_CKESR);
        end
        else if (!sref_req)
          s_nxt.st = ST_IDLE;
      end
      ST_SREF:
      begin
        s_nxt.cs_n = 1'b1;
        if (s_r.tmr <= sdrpd_pkg::TMR_W'(sdrpd_pkg::C_CKESR - sdrpd_pkg::C_CKSRE))
          s_nxt.clk_run = 1'b0;
        if (s_r.tmr == '0 && !sref_req)
        begin
          s_nxt.clk_run = 1'b1;
          s_nxt.st = ST_SRX_CLK;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_CKSRX);
        end
      end
      ST_SRX_CLK:
      begin
        s_nxt.cs_n = 1'b1;
        if (s_r.tmr == '0)
        begin
          s_nxt.cke = 1'b1;
          s_nxt.st = ST_SRX_XS;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_XS);
          s_nxt.need_ref = 1'b1;
        end
      end
      ST_SRX_XS:
      begin
        if (s_r.tmr == '0)
        begin
          s_nxt.st = ST_SRX_DLL;
          s_nxt.tmr = sdrpd_pkg::TMR_W'(sdrpd_pkg::C_XSDLL - sdrpd_pkg::C_XS);
        end
      end
      ST_SRX_DLL:
      begin
        if (s_r.tmr == '0)
          s_nxt.st = ST_IDLE;
      end
      ST_PD:
      begin
        if (s_r.tmr == '0 && (!pd_req || s_r.debt == sdrpd_pkg::DEBT_MAX))
        begin
          s_nxt.cke = 1'b1;
          s_nxt.st = ST_PDX;
          s_nxt.tmr = pd_fast ? sdrpd_pkg::TMR_W'(sdrpd_pkg::C_XP)
                              : sdrpd_pkg::TMR_W'(sdrpd_pkg::C_XPDLL);
        end
      end
      ST_PDX:
      begin
        if (s_r.tmr == '0)
          s_nxt.st = ST_IDLE;
      end
    endcase
    // Debt rises per tREFI, falls per refresh, saturates at the limits
    if (tick && !frozen && !dec && s_r.debt != sdrpd_pkg::DEBT_MAX)
      s_nxt.debt = s_r.debt + 5'sh01;
    else if (dec && !(tick && !frozen) && s_r.debt != sdrpd_pkg::DEBT_MIN)
      s_nxt.debt = s_r.debt - 5'sh01;
    s_nxt.odt = odt_req && (s_nxt.st == ST_IDLE || s_nxt.st == ST_RFC);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{st: ST_IDLE, cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
               we_n: 1'b1, clk_run: 1'b1, default: '0};
    end
    else
      s_r <= s_nxt;
  end

  assign bus.cke     = s_r.cke;
  assign bus.cs_n    = s_r.cs_n;
  assign bus.ras_n   = s_r.ras_n;
  assign bus.cas_n   = s_r.cas_n;
  assign bus.we_n    = s_r.we_n;
  assign bus.odt     = s_r.odt;
  assign bus.reset_n = arst_n;
  assign bus.clk_run = s_r.clk_run;
  assign busy        = s_r.st != ST_IDLE;
  assign in_sref     = s_r.st == ST_SREF;
  assign in_pd       = s_r.st == ST_PD;
  assign ref_sent    = s_r.ref_sent;
  assign debt        = s_r.debt;

endmodule : sdrpd_ctl_end

// *** verif/sdrpd_chk.sv ***
`timescale 1ns/1ps
module sdrpd_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic clk_run
);
  localparam logic [9:0] XS_LO = 10'(sdrpd_pkg::C_XSDLL - sdrpd_pkg::C_XS);

  logic       ref_c;
  logic       nop_c;
  logic       sre_c;
  logic [4:0] rfc_cnt_r;
  logic [9:0] dll_cnt_r;
  logic [2:0] odt_low_r;
  logic       in_sr_r;

  assign ref_c = !cs_n && !ras_n && !cas_n && we_n;
  assign nop_c = cs_n || (ras_n && cas_n && we_n);
  assign sre_c = ref_c && !cke;

  // Windows after refresh and after self-refresh exit
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      rfc_cnt_r <= 5'h00;
      dll_cnt_r <= 10'h000;
      odt_low_r <= 3'h0;
      in_sr_r   <= 1'b0;
    end
    else
    begin
      rfc_cnt_r <= (ref_c && cke) ? 5'(sdrpd_pkg::C_RFC - 1) : rfc_cnt_r - 5'((rfc_cnt_r != 5'h00));
      dll_cnt_r <= (in_sr_r && cke) ? 10'(sdrpd_pkg::C_XSDLL - 1) : dll_cnt_r - 10'((dll_cnt_r != 10'h000));
      odt_low_r <= odt ? 3'h0 : odt_low_r + 3'((odt_low_r != 3'h7));
      in_sr_r   <= sre_c || (in_sr_r && !cke);
    end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  ref_quiet_a: assert property (rfc_cnt_r != 5'h00 |-> nop_c) else $error("command inside refresh time");
  ref_cke_a: assert property (ref_c && cke |-> $past(cke)) else $error("refresh after clock enable low");
  sre_hold_a: assert property (sre_c |=> !cke [*3]) else $error("self-refresh left too early");
  sre_odt_a: assert property (sre_c |-> odt_low_r >= 3'h7) else $error("termination on at entry");
  sr_deselect_a: assert property (in_sr_r && !cke |-> cs_n) else $error("command in self-refresh");
  srx_nop_a: assert property (dll_cnt_r > XS_LO |-> nop_c) else $error("command inside exit time");
  srx_cke_a: assert property (dll_cnt_r > 10'h001 |-> cke && !odt) else $error("exit period broken");
  clk_start_a: assert property ($rose(clk_run) |-> !cke [*2]) else $error("exit before clock stable");
  clk_stop_a: assert property ($fell(clk_run) |-> in_sr_r && $past(in_sr_r)) else $error("clock stopped early");
  pd_enter_a: assert property ($fell(cke) && !ref_c |-> nop_c ##1 (nop_c && !cke)) else $error("bad power-down entry");
  cke_exit_a: assert property ($rose(cke) |-> nop_c) else $error("exit without no-op");

  cover property (ref_c && cke);
  cover property (sre_c);
  cover property ($fell(cke) && !ref_c);
  cover property ($rose(cke) && in_sr_r);
endmodule : sdrpd_chk

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic                    core_clk, arst_n, banks_idle, defer_ref, pull_ref, sref_req, pd_req, pd_fast;
  logic                    odt_req, mr1_dll_dis, mr0_pd_fast, busy, in_sref, in_pd, ref_sent;
  logic signed [4:0]       debt, max_debt;
  sdrpd_pkg::sdrpd_mode_t  mode;
  logic [14:0]             ref_row;
  logic                    ref_pulse, dll_on, dll_rst, pd_slow, bank_open, rtt_on, mem_idle, dll_seen;
  int                      mismatches, n_compared, n_ref, n_mref;

  assign mem_idle = (mode == sdrpd_pkg::SDRPD_M_IDLE);

  sdrpd_if i_sdrpd_if ();
  sdrpd_ctl_end i_sdrpd_ctl_end (.core_clk(core_clk), .arst_n(arst_n), .bus(i_sdrpd_if), .banks_idle(banks_idle),
    .defer_ref(defer_ref), .pull_ref(pull_ref), .sref_req(sref_req), .pd_req(pd_req), .pd_fast(pd_fast),
    .odt_req(odt_req), .busy(busy), .in_sref(in_sref), .in_pd(in_pd), .ref_sent(ref_sent), .debt(debt));
  sdrpd_mem_end i_sdrpd_mem_end (.core_clk(core_clk), .arst_n(arst_n), .bus(i_sdrpd_if), .mr1_dll_dis(mr1_dll_dis),
    .mr0_pd_fast(mr0_pd_fast), .mode(mode), .ref_row(ref_row), .ref_pulse(ref_pulse), .dll_on(dll_on),
    .dll_rst(dll_rst), .pd_slow(pd_slow), .bank_open(bank_open), .rtt_on(rtt_on));
  sdrpd_chk i_sdrpd_chk (.core_clk(core_clk), .arst_n(arst_n), .cke(i_sdrpd_if.cke), .cs_n(i_sdrpd_if.cs_n),
    .ras_n(i_sdrpd_if.ras_n), .cas_n(i_sdrpd_if.cas_n), .we_n(i_sdrpd_if.we_n), .odt(i_sdrpd_if.odt),
    .clk_run(i_sdrpd_if.clk_run));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    n_ref    += (ref_sent === 1'b1);
    n_mref   += (ref_pulse === 1'b1);
    dll_seen |= (dll_rst === 1'b1);
    if (debt > max_debt)
      max_debt = debt;
  end

  task test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wfor(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(negedge core_clk);
    chk("wait", 16'(v), 16'(s));
  endtask : wfor

  task t_pull;
    pull_ref = 1'b1;
    repeat (400) @(negedge core_clk);
    pull_ref = 1'b0;
    chk("refs", 16'h0008, 16'(n_ref));
    chk("mem_refs", 16'h0008, 16'(n_mref));
    chk("ref_row", 16'h0008, 16'(ref_row));
    chk("debt", 16'h0018, 16'($unsigned(debt)));
    chk("bank_open", 16'h0000, 16'(bank_open));
    chk("busy", 16'h0000, 16'(busy));
  endtask : t_pull

  task t_defer;
    int n0;
    n0 = n_ref;
    defer_ref = 1'b1;
    for (int i = 0; i < 17000 && n_ref == n0; i++)
      @(negedge core_clk);
    chk("forced_ref", 16'(n0 + 1), 16'(n_ref));
    chk("max_debt", 16'h0008, 16'($unsigned(max_debt)));
    repeat (40) @(negedge core_clk);
    chk("max_debt", 16'h0008, 16'($unsigned(max_debt)));
  endtask : t_defer

  task t_sref;
    logic signed [4:0] d0;
    int n0;
    defer_ref = 1'b0;
    odt_req   = 1'b1;
    sref_req  = 1'b1;
    wfor(in_sref, 1'b1, 800);
    repeat (10) @(negedge core_clk);
    chk("mode", 16'(sdrpd_pkg::SDRPD_M_SREF), 16'(mode));
    chk("dll_on", 16'h0000, 16'(dll_on));
    chk("rtt_on", 16'h0000, 16'(rtt_on));
    chk("clk_run", 16'h0000, 16'(i_sdrpd_if.clk_run));
    d0 = debt;
    repeat (2000) @(negedge core_clk);
    chk("sr_debt", 16'($unsigned(d0)), 16'($unsigned(debt)));
    n0 = n_ref;
    sref_req = 1'b0;
    wfor(mem_idle, 1'b1, 800);
    chk("dll_on", 16'h0001, 16'(dll_on));
    repeat (600) @(negedge core_clk);
    chk("dll_rst", 16'h0001, 16'(dll_seen));
    chk("extra_ref", 16'h0001, 16'(n_ref > n0));
    chk("rtt_on", 16'h0001, 16'(rtt_on));
    odt_req = 1'b0;
  endtask : t_sref

  task t_pd(input logic f);
    mr0_pd_fast = f;
    pd_fast     = f;
    pd_req      = 1'b1;
    wfor(in_pd, 1'b1, 300);
    repeat (3) @(negedge core_clk);
    chk("pd_mode", 16'(sdrpd_pkg::SDRPD_M_PD), 16'(mode));
    chk("pd_slow", 16'(!f), 16'(pd_slow));
    chk("pd_dll", 16'(f), 16'(dll_on));
    chk("bank_open", 16'h0000, 16'(bank_open));
    pd_req = 1'b0;
    wfor(in_pd, 1'b0, 50);
    wfor(mem_idle, 1'b1, 50);
  endtask : t_pd

  initial
  begin
    {arst_n, banks_idle, defer_ref, pull_ref, sref_req, pd_req, pd_fast, odt_req} = 8'h00;
    {mr1_dll_dis, mr0_pd_fast, dll_seen} = 3'h0;
    max_debt = 5'sh00;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    arst_n     = 1'b1;
    banks_idle = 1'b1;
    t_pull();
    t_defer();
    t_sref();
    t_pd(1'b0);
    t_pd(1'b1);
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
endmodule : tb
